// ===== pkg/uba_pkg.sv
package uba_pkg;
	// buffer memory
	localparam int RAM_BYTES = 512;
	localparam int RAM_AW = 9;
	localparam int DATA_W = 8;
	localparam int CALC_W = 11;
	localparam int NUM_BULK = 6;
	localparam int SZ_W = 3;
	localparam int ISO_UNITS_W = 5;
	localparam int OFF_W = 9;
	localparam int FIFO_DEPTH = 2;
	// sizes and units, as shift amounts
	localparam logic [10:0] MIN_BUF_BYTES = 11'h002;
	localparam logic [2:0] SZ_CODE_MAX = 3'h5;
	localparam int BULK_UNIT_SH = 1;
	localparam int BASE_UNIT_SH = 2;
	localparam int ISO_UNIT_SH = 4;
	localparam logic [3:0] ISO_EP = 4'h8;
	// register byte offsets
	localparam logic [5:0] OFS_OUT_SIZE = 6'h00;
	localparam logic [5:0] OFS_IN_SIZE = 6'h04;
	localparam logic [5:0] OFS_ISO_CFG = 6'h08;
	localparam logic [5:0] OFS_OUT_START = 6'h0C;
	localparam logic [5:0] OFS_OUT_START5 = 6'h10;
	localparam logic [5:0] OFS_IN_START = 6'h14;
	localparam logic [5:0] OFS_IN_START5 = 6'h18;
	localparam logic [5:0] OFS_REGION = 6'h1C;
	localparam logic [5:0] OFS_STATUS = 6'h20;
	// field positions
	localparam int ISO_OUT_LSB = 0;
	localparam int ISO_IN_LSB = 8;
	localparam int ISO_DBL_BIT = 16;
	localparam int STAT_ISZ_LSB = 16;
	localparam int STAT_OVF_BIT = 24;
	// reset values
	localparam logic [17:0] RST_SIZE = 18'h00000;
	localparam logic [4:0] RST_ISO_UNITS = 5'h00;
	typedef logic [SZ_W-1:0] uba_szcode_type;
endpackage

// ===== pkg/uba_ram_if.sv
`timescale 1ns/1ps
`default_nettype none
interface uba_ram_if;
	logic en;
	logic we;
	logic [uba_pkg::RAM_AW-1:0] addr;
	logic [uba_pkg::DATA_W-1:0] wdata;
	logic [uba_pkg::DATA_W-1:0] rdata;
	modport ctl (output en, output we, output addr, output wdata, input rdata);
	modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ===== rtl/uba_buf_ram.sv
`timescale 1ns/1ps
`default_nettype none
module uba_buf_ram #(
	parameter int DEPTH = uba_pkg::RAM_BYTES
) (
	input wire logic mclk,
	input wire logic rst_b,
	uba_ram_if.mem port
);
	logic [uba_pkg::DATA_W-1:0] mem_q [DEPTH];

	always_ff @(posedge mclk) begin
		if (port.en && port.we) begin
			mem_q[port.addr] <= port.wdata;
		end
	end

	// read data always leave through a register
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			port.rdata <= 8'h00;
		end else if (port.en && !port.we) begin
			port.rdata <= mem_q[port.addr];
		end
	end
endmodule // uba_buf_ram
`default_nettype wire

// ===== rtl/uba_top.sv
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - buffer memory holds 512 bytes shared by every endpoint buffer.
// - bulk/control buffers are 2, 4, 8, 16, 32 or 64 bytes.
// - isochronous buffers are whole multiples of 16 bytes.
// - bulk OUT start n is previous start plus previous size over 2.
// - bulk IN start n likewise; first IN start is ep0 IN size over 2.
// - bulk IN base is total bulk OUT size over 4.
// - iso OUT buffer starts at offset zero of the iso region.
// - iso IN start is iso OUT size over 4, relative to iso base.
// - endpoint 8 is the iso endpoint, separate IN/OUT, optional double buffer.
module uba_top (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic usb_req_valid,
	output logic usb_req_ready,
	input wire logic [3:0] usb_ep,
	input wire logic usb_dir_in,
	input wire logic usb_iso_half,
	input wire logic usb_wr,
	input wire logic [8:0] usb_offset,
	input wire logic [7:0] usb_wdata,
	output logic usb_rsp_valid,
	input wire logic usb_rsp_ready,
	output logic [7:0] usb_rsp_data,
	output logic usb_rsp_err
);
	localparam int CW = uba_pkg::CALC_W;
	localparam int NB = uba_pkg::NUM_BULK;

	uba_ram_if ram_if ();

	uba_buf_ram #(.DEPTH(uba_pkg::RAM_BYTES)) u_ram (
		.mclk(mclk),
		.rst_b(rst_b),
		.port(ram_if.mem)
	);

	////////////////////////////////////////////////////////////////////////
	// configuration registers
	logic [17:0] out_size_q;
	logic [17:0] in_size_q;
	logic [4:0] iso_out_units_q;
	logic [4:0] iso_in_units_q;
	logic iso_dbl_q;
	logic bus_req;
	logic bus_take;

	logic [31:0] be_mask, out_wr, in_wr;

	assign bus_req = avs_read || avs_write;
	assign bus_take = avs_write && !avs_waitrequest;
	assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign out_wr = ({14'h0000, out_size_q} & ~be_mask) |
		(avs_writedata & be_mask);
	assign in_wr = ({14'h0000, in_size_q} & ~be_mask) |
		(avs_writedata & be_mask);

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			out_size_q <= uba_pkg::RST_SIZE;
			in_size_q <= uba_pkg::RST_SIZE;
			iso_out_units_q <= uba_pkg::RST_ISO_UNITS;
			iso_in_units_q <= uba_pkg::RST_ISO_UNITS;
			iso_dbl_q <= 1'b0;
		end else if (bus_take) begin
			unique case (avs_address)
			uba_pkg::OFS_OUT_SIZE: begin
				out_size_q <= out_wr[17:0];
			end
			uba_pkg::OFS_IN_SIZE: begin
				in_size_q <= in_wr[17:0];
			end
			uba_pkg::OFS_ISO_CFG: begin
				if (avs_byteenable[0]) begin
					iso_out_units_q <= avs_writedata[uba_pkg::ISO_OUT_LSB +: 5];
				end
				if (avs_byteenable[1]) begin
					iso_in_units_q <= avs_writedata[uba_pkg::ISO_IN_LSB +: 5];
				end
				if (avs_byteenable[2]) begin
					iso_dbl_q <= avs_writedata[uba_pkg::ISO_DBL_BIT];
				end
			end
			default: begin
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// layout derived from the sizes, registered once per cycle
	logic [CW-1:0] ob_d [NB];
	logic [CW-1:0] ib_d [NB];
	logic [CW-1:0] os_d [NB];
	logic [CW-1:0] is_d [NB];
	logic [CW-1:0] ob_q [NB];
	logic [CW-1:0] ib_q [NB];
	logic [CW-1:0] os_q [NB];
	logic [CW-1:0] is_q [NB];
	logic [CW-1:0] out_tot_d, in_tot_d, bulk_d, iso_ob_d, iso_ib_d;
	logic [CW-1:0] in_base_q, iso_base_q, iso_in_start_q;
	logic [CW-1:0] iso_ob_q, iso_ib_q, bulk_q, total_q;
	logic ovf_q;

	function automatic logic [CW-1:0] code_bytes(input uba_pkg::uba_szcode_type c);
		uba_pkg::uba_szcode_type k;
		// codes above 64 bytes are held at 64 so no buffer is ever illegal
		k = (c > uba_pkg::SZ_CODE_MAX) ? uba_pkg::SZ_CODE_MAX : c;
		return uba_pkg::MIN_BUF_BYTES << k;
	endfunction

	always_comb begin
		for (int i = 0; i < NB; i++) begin
			ob_d[i] = code_bytes(out_size_q[i*3 +: 3]);
			ib_d[i] = code_bytes(in_size_q[i*3 +: 3]);
		end
		os_d[0] = '0;
		is_d[0] = '0;
		for (int i = 1; i < NB; i++) begin
			os_d[i] = os_d[i-1] + (ob_d[i-1] >> uba_pkg::BULK_UNIT_SH);
			is_d[i] = is_d[i-1] + (ib_d[i-1] >> uba_pkg::BULK_UNIT_SH);
		end
		out_tot_d = (os_d[NB-1] << uba_pkg::BULK_UNIT_SH) + ob_d[NB-1];
		in_tot_d = (is_d[NB-1] << uba_pkg::BULK_UNIT_SH) + ib_d[NB-1];
		bulk_d = out_tot_d + in_tot_d;
		iso_ob_d = CW'(iso_out_units_q) << uba_pkg::ISO_UNIT_SH;
		iso_ib_d = CW'(iso_in_units_q) << uba_pkg::ISO_UNIT_SH;
	end

	// no reset: the layout follows the reset sizes while reset is held
	always_ff @(posedge mclk) begin
		ob_q <= ob_d;
		ib_q <= ib_d;
		os_q <= os_d;
		is_q <= is_d;
		in_base_q <= out_tot_d >> uba_pkg::BASE_UNIT_SH;
		iso_base_q <= bulk_d >> uba_pkg::ISO_UNIT_SH;
		iso_in_start_q <= iso_ob_d >> uba_pkg::BASE_UNIT_SH;
		iso_ob_q <= iso_ob_d;
		iso_ib_q <= iso_ib_d;
		bulk_q <= bulk_d;
		total_q <= bulk_d + iso_ob_d + iso_ib_d;
		ovf_q <= (bulk_d + iso_ob_d + iso_ib_d) >
			CW'(uba_pkg::RAM_BYTES);
	end

	////////////////////////////////////////////////////////////////////////
	// register read side; one wait state on every access
	logic [31:0] rd_d;

	always_comb begin
		rd_d = 32'h00000000;
		unique case (avs_address)
		uba_pkg::OFS_OUT_SIZE: rd_d = {14'h0000, out_size_q};
		uba_pkg::OFS_IN_SIZE: rd_d = {14'h0000, in_size_q};
		uba_pkg::OFS_ISO_CFG: begin
			rd_d[uba_pkg::ISO_OUT_LSB +: 5] = iso_out_units_q;
			rd_d[uba_pkg::ISO_IN_LSB +: 5] = iso_in_units_q;
			rd_d[uba_pkg::ISO_DBL_BIT] = iso_dbl_q;
		end
		uba_pkg::OFS_OUT_START: rd_d = {os_q[4][7:0], os_q[3][7:0],
			os_q[2][7:0], os_q[1][7:0]};
		uba_pkg::OFS_OUT_START5: rd_d = {24'h000000, os_q[5][7:0]};
		uba_pkg::OFS_IN_START: rd_d = {is_q[4][7:0], is_q[3][7:0],
			is_q[2][7:0], is_q[1][7:0]};
		uba_pkg::OFS_IN_START5: rd_d = {24'h000000, is_q[5][7:0]};
		// iso OUT start is the fixed zero in byte 2
		uba_pkg::OFS_REGION: rd_d = {iso_in_start_q[7:0], 8'h00,
			iso_base_q[7:0], in_base_q[7:0]};
		uba_pkg::OFS_STATUS: begin
			rd_d[CW-1:0] = total_q;
			rd_d[uba_pkg::STAT_ISZ_LSB +: 5] = iso_out_units_q;
			rd_d[uba_pkg::STAT_OVF_BIT] = ovf_q;
		end
		default: rd_d = 32'h00000000;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
		end else if (bus_req && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
			avs_readdata <= rd_d;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// endpoint request to buffer address
	logic accept;
	logic [CW-1:0] lim, base, phys;
	logic req_err;

	assign accept = usb_req_valid && usb_req_ready;

	always_comb begin
		lim = '0;
		base = '0;
		req_err = 1'b0;
		if (usb_ep < 4'(NB)) begin
			lim = usb_dir_in ? ib_q[usb_ep[2:0]] : ob_q[usb_ep[2:0]];
			base = usb_dir_in ?
				(in_base_q << uba_pkg::BASE_UNIT_SH) +
				(is_q[usb_ep[2:0]] << uba_pkg::BULK_UNIT_SH) :
				os_q[usb_ep[2:0]] << uba_pkg::BULK_UNIT_SH;
		end else if (usb_ep == uba_pkg::ISO_EP) begin
			lim = usb_dir_in ? iso_ib_q : iso_ob_q;
			base = (iso_base_q << uba_pkg::ISO_UNIT_SH) + (usb_dir_in ?
				iso_in_start_q << uba_pkg::BASE_UNIT_SH : '0);
			// double buffering splits each iso buffer into two halves
			if (iso_dbl_q) begin
				lim = lim >> 1;
				base = base + (usb_iso_half ? lim : '0);
			end
		end else begin
			req_err = 1'b1;
		end
		phys = base + CW'(usb_offset);
		if (CW'(usb_offset) >= lim || phys >= CW'(uba_pkg::RAM_BYTES)) begin
			req_err = 1'b1;
		end
	end

	assign ram_if.en = accept && !req_err;
	assign ram_if.we = usb_wr;
	assign ram_if.addr = phys[uba_pkg::RAM_AW-1:0];
	assign ram_if.wdata = usb_wdata;

	////////////////////////////////////////////////////////////////////////
	// two-entry answer buffer; ready counts the answer still in flight
	logic pend_q, pend_err_q, pend_wr_q;
	logic [1:0] cnt_q, cnt_d;
	logic [8:0] ent1_q, new_ent;
	logic push, pop;

	assign push = pend_q;
	assign pop = usb_rsp_valid && usb_rsp_ready;
	assign new_ent = {pend_err_q, (pend_err_q || pend_wr_q) ? 8'h00 : ram_if.rdata};
	assign cnt_d = cnt_q + 2'(push) - 2'(pop);

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			pend_q <= 1'b0;
			pend_err_q <= 1'b0;
			pend_wr_q <= 1'b0;
		end else begin
			pend_q <= accept;
			pend_err_q <= req_err;
			pend_wr_q <= usb_wr;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			cnt_q <= 2'h0;
			ent1_q <= 9'h000;
			usb_rsp_valid <= 1'b0;
			usb_rsp_err <= 1'b0;
			usb_rsp_data <= 8'h00;
			usb_req_ready <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			usb_rsp_valid <= cnt_d != 2'h0;
			usb_req_ready <= (3'(cnt_d) + 3'(accept)) < 3'(uba_pkg::FIFO_DEPTH);
			if ((cnt_q == 2'h0 && push) || (cnt_q == 2'h1 && push && pop)) begin
				{usb_rsp_err, usb_rsp_data} <= new_ent;
			end else if (cnt_q == 2'h2 && pop) begin
				{usb_rsp_err, usb_rsp_data} <= ent1_q;
			end
			if (push && cnt_q == 2'h1 && !pop) begin
				ent1_q <= new_ent;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	property p_ram_bound;
		accept && phys >= CW'(uba_pkg::RAM_BYTES) |-> !ram_if.en ##1 pend_err_q;
	endproperty
	a_ram_bound: assert property (p_ram_bound) else $error("out of memory access");
	property p_bulk_size;
		$onehot(ob_q[1]) && ob_q[1] >= 11'h002 && ob_q[1] <= 11'h040;
	endproperty
	a_bulk_size: assert property (p_bulk_size) else $error("bulk size illegal");
	property p_iso_mult;
		iso_ob_q[3:0] == 4'h0 && iso_ib_q[3:0] == 4'h0;
	endproperty
	a_iso_mult: assert property (p_iso_mult) else $error("iso size not x16");
	property p_out_chain;
		os_q[2] == os_q[1] + (ob_q[1] >> 1) && os_q[0] == 11'h000;
	endproperty
	a_out_chain: assert property (p_out_chain) else $error("bulk out start wrong");
	property p_in_chain;
		is_q[1] == (ib_q[0] >> 1) && is_q[5] == is_q[4] + (ib_q[4] >> 1);
	endproperty
	a_in_chain: assert property (p_in_chain) else $error("bulk in start wrong");
	property p_in_base;
		$stable(out_size_q) |=> in_base_q == (os_q[5] * 2 + ob_q[5]) / 4;
	endproperty
	a_in_base: assert property (p_in_base) else $error("in base wrong");
	logic [CW-1:0] iso_base_bytes;
	assign iso_base_bytes = iso_base_q * 11'h010;
	property p_iso_out_zero;
		accept && usb_ep == 4'h8 && !usb_dir_in && usb_offset == 9'h000 &&
			!iso_dbl_q && !req_err |->
			ram_if.addr == iso_base_bytes[uba_pkg::RAM_AW-1:0];
	endproperty
	a_iso_out_zero: assert property (p_iso_out_zero) else $error("iso out not at base");
	property p_iso_in_start;
		$stable(iso_out_units_q) |=> iso_in_start_q * 4 == iso_ob_q;
	endproperty
	a_iso_in_start: assert property (p_iso_in_start) else $error("iso in start wrong");
	property p_ep_refused;
		accept && usb_ep > 4'h5 && usb_ep != 4'h8 |-> ##1 pend_err_q ##1 (cnt_q != 2'h0);
	endproperty
	a_ep_refused: assert property (p_ep_refused) else $error("bad endpoint taken");
	property p_iso_base;
		iso_base_q * 16 == $past(bulk_d) - ($past(bulk_d) % 16);
	endproperty
	a_iso_base: assert property (p_iso_base) else $error("iso base wrong");
endmodule // uba_top
`default_nettype wire

// ===== verification/uba_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the endpoint path; answers are taken with random stalls
module uba_host_model (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic stall,
	input wire logic usb_req_ready,
	input wire logic usb_rsp_valid,
	input wire logic [7:0] usb_rsp_data,
	input wire logic usb_rsp_err,
	output logic usb_req_valid,
	output logic [3:0] usb_ep,
	output logic usb_dir_in,
	output logic usb_iso_half,
	output logic usb_wr,
	output logic [8:0] usb_offset,
	output logic [7:0] usb_wdata,
	output logic usb_rsp_ready
);
	logic [23:0] rq[$];
	logic [8:0] aq[$];
	logic [23:0] fld_q = 24'h000000;
	int sd = 32'h1D5;
	assign {usb_ep, usb_dir_in, usb_iso_half, usb_wr, usb_offset, usb_wdata} = fld_q;
	initial begin
		usb_req_valid = 1'b0;
		usb_rsp_ready = 1'b0;
	end
	task push(input logic [23:0] r);
		rq.push_back(r);
	endtask
	always @(posedge mclk) begin
		if (!rst_b) begin
			usb_req_valid <= 1'b0;
			usb_rsp_ready <= 1'b0;
		end else begin
			// one request in flight, held until ready is seen high
			if (usb_req_valid && usb_req_ready)
				void'(rq.pop_front());
			if (!usb_req_valid || usb_req_ready) begin
				usb_req_valid <= rq.size() > 0;
				// idle lines never keep the last request
				fld_q <= (rq.size() > 0) ? rq[0] : ~fld_q;
			end
			usb_rsp_ready <= !stall && (($random(sd) & 3) != 0);
			if (usb_rsp_valid && usb_rsp_ready)
				aq.push_back({usb_rsp_err, usb_rsp_data});
		end
	end
endmodule // uba_host_model
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic stall = 1'b0;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [3:0] avs_byteenable = 4'hF;
	wire logic [31:0] avs_readdata;
	wire logic avs_waitrequest;
	wire logic usb_req_valid, usb_req_ready, usb_dir_in, usb_iso_half, usb_wr;
	wire logic [3:0] usb_ep;
	wire logic [8:0] usb_offset;
	wire logic [7:0] usb_wdata, usb_rsp_data;
	wire logic usb_rsp_valid, usb_rsp_ready, usb_rsp_err;
	int n_fail = 0;
	int compares = 0;
	int cyc = 0;
	int seed = 32'h6bd0;
	logic [31:0] rd;
	logic [17:0] oc = 18'h00000, ic = 18'h00000;
	logic [4:0] ou = 5'h00, iu = 5'h00;
	logic dbl = 1'b0;
	logic [7:0] mem_m [512];
	logic known_m [512];
	logic [9:0] eq[$];
	uba_top i_dut (.mclk, .rst_b, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.usb_req_valid, .usb_req_ready, .usb_ep, .usb_dir_in, .usb_iso_half,
		.usb_wr, .usb_offset, .usb_wdata, .usb_rsp_valid, .usb_rsp_ready,
		.usb_rsp_data, .usb_rsp_err);
	uba_host_model i_host (.mclk, .rst_b, .stall, .usb_req_ready,
		.usb_rsp_valid, .usb_rsp_data, .usb_rsp_err, .usb_req_valid, .usb_ep,
		.usb_dir_in, .usb_iso_half, .usb_wr, .usb_offset, .usb_wdata,
		.usb_rsp_ready);
	always #12.5 mclk = ~mclk;
	////////////////////////////////////////////////////////////////////
	task close_out;
		if (n_fail == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// generous ceiling: the whole run needs well under 20000 cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			close_out;
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		// no count of its own: only the bench ceiling ends a hang
		do begin
			@(posedge mclk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask
	////////////////////////////////////////////////////////////////////
	function automatic int sz(logic [17:0] f, int e);
		return 2 << f[3*e +: 3];
	endfunction
	function automatic int tot(logic [17:0] f);
		tot = 0;
		for (int k = 0; k < 6; k++)
			tot += sz(f, k);
	endfunction
	function automatic int start(logic [17:0] f, int e);
		start = 0;
		for (int k = 0; k < e; k++)
			start += sz(f, k) / 2;
	endfunction
	function automatic int phys(logic [3:0] ep, logic d, logic h, int off);
		int s;
		if (ep <= 4'h5) begin
			s = sz(d ? ic : oc, ep);
			phys = (d ? (tot(oc) / 4) * 4 : 0) + start(d ? ic : oc, ep) * 2;
		end else if (ep == 4'h8) begin
			// double buffering gives each half its own limit
			s = dbl ? 8 * (d ? iu : ou) : 16 * (d ? iu : ou);
			phys = ((tot(oc) + tot(ic)) / 16) * 16 + (d ? ou * 16 : 0);
			phys += (dbl && h) ? s : 0;
		end else
			return -1;
		phys += off;
		if (off >= s || phys >= 512)
			phys = -1;
	endfunction
	function automatic logic [31:0] ereg(logic [5:0] a);
		int b;
		b = tot(oc) + tot(ic) + 16 * (ou + iu);
		case (a)
			6'h00: return {14'h0000, oc};
			6'h04: return {14'h0000, ic};
			6'h08: return {15'h0000, dbl, 3'h0, iu, 3'h0, ou};
			6'h0C: return {8'(start(oc, 4)), 8'(start(oc, 3)),
				8'(start(oc, 2)), 8'(start(oc, 1))};
			6'h10: return {24'h000000, 8'(start(oc, 5))};
			6'h14: return {8'(start(ic, 4)), 8'(start(ic, 3)),
				8'(start(ic, 2)), 8'(start(ic, 1))};
			6'h18: return {24'h000000, 8'(start(ic, 5))};
			6'h1C: return {8'(ou * 4), 8'h00, 8'((tot(oc) + tot(ic)) / 16),
				8'(tot(oc) / 4)};
			6'h20: return {7'h00, 1'(b > 512), 3'h0, ou, 5'h00, 11'(b)};
			default: return 32'h00000000;
		endcase
	endfunction
	////////////////////////////////////////////////////////////////////
	task req(input logic [3:0] ep, input logic d, input logic h, input int off);
		int a;
		logic w;
		logic [7:0] wd;
		w = $random(seed);
		wd = $random(seed);
		a = phys(ep, d, h, off);
		i_host.push({ep, d, h, w, 9'(off), wd});
		if (a < 0)
			eq.push_back(10'h300);
		else if (w) begin
			mem_m[a] = wd;
			known_m[a] = 1'b1;
			eq.push_back(10'h200);
		end else
			eq.push_back({known_m[a], 1'b0, mem_m[a]});
	endtask
	task drain;
		int n;
		logic [9:0] e;
		logic [8:0] m;
		n = 0;
		while (i_host.aq.size() < eq.size() && n < 3000) begin
			@(posedge mclk);
			n++;
		end
		while (eq.size() > 0 && i_host.aq.size() > 0) begin
			e = eq.pop_front();
			// data of a never-written byte is not known
			m = {1'b1, {8{e[9]}}};
			chk(i_host.aq.pop_front() & m, e[8:0] & m);
		end
		chk(eq.size(), 0);
	endtask
	task scan;
		bus(1'b1, 6'h1C, $random(seed));
		bus(1'b1, 6'h24, $random(seed));
		for (int a = 0; a < 64; a += 4) begin
			bus(1'b0, 6'(a), 32'h00000000);
			chk(rd, ereg(6'(a)));
		end
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		int s;
		int b;
		logic [3:0] ep;
		logic d;
		for (int k = 0; k < 512; k++)
			known_m[k] = 1'b0;
		repeat (10) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		scan;
		for (int t = 0; t < 7; t++) begin
			// two fixed corners: six 32-byte pairs, then an oversized layout
			oc = (t == 0) ? 18'o444444 : (t == 1) ? 18'o555555 : 18'h00000;
			for (int k = 0; k < 6 && t > 1; k++)
				oc[3*k +: 3] = 3'(($random(seed) & 32'hFF) % 6);
			ic = (t < 2) ? oc : {oc[8:0], oc[17:9]};
			ou = (t == 0) ? 5'h02 : 5'(($random(seed) & 7) % 5);
			iu = (t == 0) ? 5'h02 : 5'(($random(seed) & 7) % 5);
			dbl = (t == 0) ? 1'b1 : 1'($random(seed));
			bus(1'b1, 6'h00, {14'h0000, oc});
			bus(1'b1, 6'h04, {14'h0000, ic});
			bus(1'b1, 6'h08, {15'h0000, dbl, 3'h0, iu, 3'h0, ou});
			scan;
			repeat (60) begin
				ep = 4'($random(seed));
				d = $random(seed);
				if (ep > 4'h5 && ep != 4'h8 && ($random(seed) & 3) != 0)
					ep = 4'h8;
				s = (ep <= 4'h5) ? sz(d ? ic : oc, ep) : 16 * (d ? iu : ou);
				b = s + 2;
				b = (ep > 4'h5 && ep != 4'h8) ? 64 : b;
				req(ep, d, $random(seed), (b < 1) ? 0 : ($random(seed) & 511) % b);
			end
			drain;
		end
		// receiver stalls: two answers held, the third request must wait
		stall <= 1'b1;
		repeat (6)
			req(4'h0, 1'b0, 1'b0, 0);
		repeat (12) @(posedge mclk);
		chk(usb_req_ready, 1'b0);
		stall <= 1'b0;
		drain;
		close_out;
	end
endmodule // tb_top
`default_nettype wire
